// *** core/spio_pkg.sv ***
// Purpose: Shared constants and types of the stepper pulse-input front end.
// Assumes: A 10 MHz system clock.
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
package spio_pkg;
  // Clock period and the derived clock rate.
  localparam int CLK_NS = 100;
  localparam int CLK_HZ = 1_000_000_000 / CLK_NS;
  // One millisecond, rounded up to whole cycles.
  localparam int MS_NS  = 1_000_000;
  localparam int MS_CYC = (MS_NS + CLK_NS - 1) / CLK_NS;
  // One unit of the request frequency limit, in hertz.
  localparam int HZ_PER_UNIT = 100;
  // Register offsets.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_TCONST = 8'h04;
  localparam logic [7:0] A_MAXF   = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0C;
  localparam logic [7:0] A_LOST   = 8'h10;
  localparam logic [7:0] A_CPOS   = 8'h14;
  // Filter selections.
  localparam logic [1:0] FILT_LPF = 2'h1;
  localparam logic [1:0] FILT_MA  = 2'h2;
  // Setting limits and reset values.
  localparam logic [4:0]  MULT_MIN = 5'h02;
  localparam logic [4:0]  MULT_MAX = 5'h1E;
  localparam logic [7:0]  TC_MAX   = 8'hC8;
  localparam logic [7:0]  TC_RST   = 8'h01;
  localparam logic [13:0] MAXF_MAX = 14'h2710;
  localparam logic [13:0] MAXF_RST = 14'h0064;
  localparam logic [31:0] CTRL_RST = 32'h00000A01;
  // Index of the last serial monitor frame bit.
  localparam logic [5:0] FRAME_LAST = 6'h2F;
  // Control register layout.
  typedef struct packed {
    logic [6:0] r3;
    logic       mon_pulse;   // Monitor clock drives the pulse request, not serial.
    logic [1:0] r2;
    logic [1:0] prq_src;     // Request data source code 0 to 3.
    logic [2:0] r1;
    logic       lost_signed; // Lost pulses counted with direction.
    logic [2:0] r0;
    logic [4:0] mult;        // Pulse multiplying factor.
    logic [5:0] rz;
    logic [1:0] filt;        // Command filter type.
  } spio_ctrl_s;
  // Synchronised input pins, high bit first.
  typedef struct packed {
    logic req_sel;
    logic push;
    logic dis;
    logic mult;
    logic latch_clr;
    logic monitor_clock_input;
    logic dir;
    logic step;
  } spio_pins_s;
  // Pulse request states.
  typedef enum logic [2:0] {
    PRQ_IDLE  = 3'b001,
    PRQ_ARMED = 3'b010,
    PRQ_SEND  = 3'b100
  } spio_prq_e;
endpackage

// *** core/spio_top.sv ***
// Purpose: Pulse-input front end: filter, multiply, lost pulses, monitor.
// Assumes: Pins are asynchronous; motor status inputs are on i_clk.
// Notes: Registers sit on an Avalon-MM slave with one wait cycle.
//
// Summary of operation
// - Filter type 1 lowpass, 2 moving average.
// - Time constant 0 to 200 ms, reset 1.
// - Lowpass smooths with longer time constant.
// - Moving average over time constant window.
// - Ready and ready LED rise together.
// - Multiply input scales pulses by 2 to 30.
// - Pulse disable input drops command pulses.
// - Push-motion input masks overload alarm.
// - Monitor clock rise drives next serial bit.
// - Monitor clock rise starts pulse request train.
// - Request select input sets up the data.
// - Request source codes 0 to 3.
// - Request rate capped, 0.1 kHz units.
// - Pulse ready when pulse motion possible.
// - Serial output carries position and alarm.
// - Request ready until pulse train ends.
// - Pulse while not ready sets lost flag.
// - Latch clear rise clears lost flag.
// - Unexcited, stop or disable drop pulse ready.
// - Lost pulses counted unsigned or signed.
// - A and B quadrature from feedback position.
// - Step pulse input with direction input.
// - Serial frame LSB first, with checksum.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module spio_top #(
  parameter int MS_CYC_P = spio_pkg::MS_CYC, // Cycles per millisecond.
  parameter int PREP_CYC = 300               // Start-up preparation cycles.
) (
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  input  wire spio_pkg::spio_pins_s i_pins,
  input  wire logic                i_excited,
  input  wire logic                i_stop,
  input  wire logic                i_overload,
  input  wire logic [31:0]         i_fb_pos,
  input  wire logic [7:0]          i_alarm_code,
  input  wire logic [7:0]          i_address,
  input  wire logic                i_read,
  input  wire logic                i_write,
  input  wire logic [31:0]         i_writedata,
  input  wire logic [3:0]          i_byteenable,
  output logic [31:0]              o_readdata,
  output logic                     o_waitrequest,
  output logic                     o_ready,
  output logic                     o_ready_led,
  output logic                     o_pulse_ready,
  output logic                     o_lost_flag,
  output logic                     o_overload_alarm,
  output logic                     o_mon_data,
  output logic                     o_pulse_req,
  output logic                     o_pulse_req_dir,
  output logic                     o_prq_ready,
  output logic                     o_phase_a,
  output logic                     o_phase_b
);
  localparam int NP = $bits(spio_pkg::spio_pins_s);

  // Refuse settings the counters cannot serve.
  if (MS_CYC_P < 2 || PREP_CYC < 256 || MS_CYC_P > 65536 || PREP_CYC > 65536) begin : g_bad
    $error("spio_top: MS_CYC_P 2..65536 and PREP_CYC 256..65536 required");
  end

  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [NP-1:0] s1, s2, s3, pin_q, pin_d;
  spio_pkg::spio_pins_s p, rise;
  for (genvar i = 0; i < NP; i++) begin : g_sync
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        s1[i]    <= 1'b0;
        s2[i]    <= 1'b0;
        s3[i]    <= 1'b0;
        pin_q[i] <= 1'b0;
        pin_d[i] <= 1'b0;
      end else begin
        s1[i] <= i_pins[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        pin_d[i] <= pin_q[i];
        if (s2[i] == s3[i]) begin
          pin_q[i] <= s3[i];
        end
      end
    end
  end
  assign p    = pin_q;
  assign rise = pin_q & ~pin_d;

  // Software settings.
  spio_pkg::spio_ctrl_s ctrl_reg;
  logic [7:0]  tc_reg;
  logic [13:0] maxf_reg;
  logic [31:0] wmask, rd_next, lost_cnt_reg, cmd_pos;
  logic        wait_reg, do_wr;
  assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  assign do_wr = i_write && !wait_reg;

  // Waitrequest falls for one cycle after a request is seen.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wait_reg   <= 1'b1;
      o_readdata <= 32'h00000000;
    end else begin
      wait_reg <= !((i_read || i_write) && wait_reg);
      if (i_read && wait_reg) begin
        o_readdata <= rd_next;
      end
    end
  end
  assign o_waitrequest = wait_reg;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_next = 32'h00000000;
    if (i_address == spio_pkg::A_CTRL) begin
      rd_next = ctrl_reg;
    end else if (i_address == spio_pkg::A_TCONST) begin
      rd_next = {24'h000000, tc_reg};
    end else if (i_address == spio_pkg::A_MAXF) begin
      rd_next = {18'h00000, maxf_reg};
    end else if (i_address == spio_pkg::A_STAT) begin
      rd_next = {27'h0000000, o_overload_alarm, o_prq_ready, o_lost_flag,
                 o_pulse_ready, o_ready};
    end else if (i_address == spio_pkg::A_LOST) begin
      rd_next = lost_cnt_reg;
    end else if (i_address == spio_pkg::A_CPOS) begin
      rd_next = cmd_pos;
    end
  end

  // Register writes; values out of range are ignored and the old one kept.
  spio_pkg::spio_ctrl_s cw;
  logic [31:0] ww;
  assign cw = (ctrl_reg & ~wmask) | (i_writedata & wmask);
  assign ww = i_writedata & wmask;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl_reg <= spio_pkg::CTRL_RST;
      tc_reg   <= spio_pkg::TC_RST;
      maxf_reg <= spio_pkg::MAXF_RST;
    end else if (do_wr) begin
      if (i_address == spio_pkg::A_CTRL) begin
        if ((cw.filt == spio_pkg::FILT_LPF || cw.filt == spio_pkg::FILT_MA)
            && cw.mult >= spio_pkg::MULT_MIN && cw.mult <= spio_pkg::MULT_MAX) begin
          ctrl_reg <= cw;
        end
      end else if (i_address == spio_pkg::A_TCONST) begin
        if (ww[31:8] == 24'h000000 && ww[7:0] <= spio_pkg::TC_MAX) begin
          tc_reg <= ww[7:0];
        end
      end else if (i_address == spio_pkg::A_MAXF) begin
        if (ww[31:14] == 18'h00000 && ww[13:0] != 14'h0000
            && ww[13:0] <= spio_pkg::MAXF_MAX) begin
          maxf_reg <= ww[13:0];
        end
      end
    end
  end

  // Preparation counter; ready and its LED rise on the same edge.
  logic [15:0] prep_cnt;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prep_cnt    <= 16'h0000;
      o_ready     <= 1'b0;
      o_ready_led <= 1'b0;
    end else if (prep_cnt == 16'(PREP_CYC - 1)) begin
      o_ready     <= 1'b1;
      o_ready_led <= 1'b1;
    end else begin
      prep_cnt <= prep_cnt + 16'h0001;
    end
  end

  // Pulse ready, and overload alarm masked during push motion.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pulse_ready    <= 1'b0;
      o_overload_alarm <= 1'b0;
    end else begin
      o_pulse_ready    <= o_ready && i_excited && !i_stop && !p.dis;
      o_overload_alarm <= i_overload && !p.push;
    end
  end

  // Millisecond tick paces the command filter.
  logic [15:0] ms_cnt;
  logic        ms_tick, tick_d, tick_d2;
  assign ms_tick = (ms_cnt == 16'(MS_CYC_P - 1));
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ms_cnt  <= 16'h0000;
      tick_d  <= 1'b0;
      tick_d2 <= 1'b0;
    end else begin
      ms_cnt  <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
      tick_d  <= ms_tick;
      tick_d2 <= tick_d;
    end
  end

  // Accepted pulses per millisecond, multiplied and signed by direction.
  logic signed [15:0] step_inc, rin_acc, rin;
  logic               take;
  assign take = rise.step && o_pulse_ready;
  always_comb begin
    step_inc = 16'sh0000;
    if (take) begin
      step_inc = p.mult ? signed'({11'h000, ctrl_reg.mult}) : 16'sh0001;
      if (p.dir) begin
        step_inc = -step_inc;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rin_acc <= 16'sh0000;
      rin     <= 16'sh0000;
    end else if (ms_tick) begin
      rin     <= rin_acc + step_inc;
      rin_acc <= 16'sh0000;
    end else begin
      rin_acc <= rin_acc + step_inc;
    end
  end

  // Lost pulses: flag set wins over clear; count unsigned or signed.
  logic lost_ev;
  assign lost_ev = rise.step && !o_pulse_ready;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_lost_flag  <= 1'b0;
      lost_cnt_reg <= 32'h00000000;
    end else begin
      if (lost_ev) begin
        o_lost_flag  <= 1'b1;
        lost_cnt_reg <= (ctrl_reg.lost_signed && p.dir) ? lost_cnt_reg - 32'h00000001
                                                        : lost_cnt_reg + 32'h00000001;
      end else if (rise.latch_clr) begin
        o_lost_flag <= 1'b0;
      end
    end
  end

  // Moving-average history, cleared during preparation.
  logic signed [15:0] hist [0:255];
  logic [7:0]         widx, clr_idx;
  logic signed [23:0] ma_sum;
  logic signed [31:0] rate, rate_n, filt, den, lp_diff, lp_step;
  logic signed [39:0] cmd_acc;
  assign den = signed'({24'h000000, tc_reg});
  always_ff @(posedge i_clk) begin
    if (!o_ready) begin
      hist[clr_idx] <= 16'sh0000;
    end else if (tick_d) begin
      hist[widx] <= rin;
    end
  end

  // Filter state: window sum and lowpass rate, eight fraction bits.
  always_comb begin
    lp_diff = {{8{rin[15]}}, rin, 8'h00} - rate;
    lp_step = lp_diff;
    if (tc_reg != 8'h00) begin
      lp_step = lp_diff / den;
      // A residue below the divisor would otherwise stick and drift the position.
      if (lp_step == 32'sh00000000 && lp_diff != 32'sh00000000) begin
        lp_step = lp_diff[31] ? -32'sh00000001 : 32'sh00000001;
      end
    end
    rate_n = rate + lp_step;
    filt = {{8{rin[15]}}, rin, 8'h00};
    if (tc_reg != 8'h00) begin
      if (ctrl_reg.filt == spio_pkg::FILT_MA) begin
        filt = signed'({ma_sum, 8'h00}) / den;
      end else begin
        filt = rate;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      widx    <= 8'h00;
      clr_idx <= 8'h00;
      ma_sum  <= 24'sh000000;
      rate    <= 32'sh00000000;
      cmd_acc <= 40'sh0000000000;
    end else begin
      if (!o_ready) begin
        clr_idx <= clr_idx + 8'h01;
      end
      if (tick_d) begin
        widx   <= widx + 8'h01;
        ma_sum <= ma_sum + 24'(rin) - 24'(hist[8'(widx - tc_reg)]);
        rate   <= rate_n;
      end
      if (tick_d2) begin
        cmd_acc <= cmd_acc + 40'(filt);
      end
    end
  end
  // Rounding keeps the small per-tick division losses from shaving off a whole step.
  assign cmd_pos = cmd_acc[39:8] + {31'h00000000, cmd_acc[7]};

  // Quadrature output tracks the feedback position one count per cycle.
  logic [31:0] q_pos, q_diff;
  assign q_diff = i_fb_pos - q_pos;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q_pos     <= 32'h00000000;
      o_phase_a <= 1'b0;
      o_phase_b <= 1'b0;
    end else begin
      if (q_diff != 32'h00000000) begin
        q_pos <= q_diff[31] ? q_pos - 32'h00000001 : q_pos + 32'h00000001;
      end
      o_phase_a <= q_pos[1];
      o_phase_b <= q_pos[1] ^ q_pos[0];
    end
  end

  // Serial monitor: frame of position, alarm and checksum, LSB first.
  logic [31:0] pos_sel;
  logic [7:0]  csum;
  logic [46:0] ser_sh;
  logic [5:0]  bit_cnt;
  assign pos_sel = ctrl_reg.prq_src[1] ? i_fb_pos : cmd_pos;
  assign csum = pos_sel[7:0] + pos_sel[15:8] + pos_sel[23:16] + pos_sel[31:24]
              + i_alarm_code;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ser_sh     <= 47'h0;
      bit_cnt    <= 6'h00;
      o_mon_data <= 1'b0;
    end else if (rise.monitor_clock_input && !ctrl_reg.mon_pulse) begin
      if (bit_cnt == 6'h00) begin
        o_mon_data <= pos_sel[0];
        ser_sh     <= {csum, i_alarm_code, pos_sel[31:1]};
      end else begin
        o_mon_data <= ser_sh[0];
        ser_sh     <= {1'b0, ser_sh[46:1]};
      end
      bit_cnt <= (bit_cnt == spio_pkg::FRAME_LAST) ? 6'h00 : bit_cnt + 6'h01;
    end
  end

  // Pulse request: set up on select, start on monitor clock, paced train.
  spio_pkg::spio_prq_e prq_state;
  logic [31:0] prq_left, half_cnt, half_per, prq_val;
  assign prq_val = ctrl_reg.prq_src[1] ? i_fb_pos : cmd_pos;
  assign half_per = 32'((spio_pkg::CLK_HZ + 2 * spio_pkg::HZ_PER_UNIT * int'(maxf_reg) - 1)
                  / (2 * spio_pkg::HZ_PER_UNIT * int'(maxf_reg)));
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      prq_state       <= spio_pkg::PRQ_IDLE;
      prq_left        <= 32'h00000000;
      half_cnt        <= 32'h00000000;
      o_pulse_req     <= 1'b0;
      o_pulse_req_dir <= 1'b0;
      o_prq_ready     <= 1'b0;
    end else begin
      case (prq_state)
        spio_pkg::PRQ_IDLE: begin
          if (ctrl_reg.mon_pulse && rise.req_sel) begin
            prq_left        <= prq_val[31] ? -prq_val : prq_val;
            o_pulse_req_dir <= prq_val[31];
            o_prq_ready     <= 1'b1;
            prq_state       <= spio_pkg::PRQ_ARMED;
          end
        end
        spio_pkg::PRQ_ARMED: begin
          if (rise.monitor_clock_input) begin
            half_cnt  <= 32'h00000001;
            prq_state <= spio_pkg::PRQ_SEND;
          end
        end
        spio_pkg::PRQ_SEND: begin
          if (prq_left == 32'h00000000) begin
            o_prq_ready <= 1'b0;
            prq_state   <= spio_pkg::PRQ_IDLE;
          end else if (half_cnt == half_per) begin
            half_cnt    <= 32'h00000001;
            o_pulse_req <= !o_pulse_req;
            if (o_pulse_req) begin
              prq_left <= prq_left - 32'h00000001;
            end
          end else begin
            half_cnt <= half_cnt + 32'h00000001;
          end
        end
        default: begin
          prq_state <= spio_pkg::PRQ_IDLE;
        end
      endcase
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_led; o_ready == o_ready_led; endproperty
  a_led: assert property (p_led) else $error("ready LED differs");
  property p_dis; p.dis |=> !o_pulse_ready; endproperty
  a_dis: assert property (p_dis) else $error("pulse ready while disabled");
  property p_lost; lost_ev |=> o_lost_flag; endproperty
  a_lost: assert property (p_lost) else $error("lost flag not set");
  property p_clr; rise.latch_clr && !lost_ev |=> !o_lost_flag; endproperty
  a_clr: assert property (p_clr) else $error("lost flag not cleared");
  property p_ovl; p.push |=> !o_overload_alarm; endproperty
  a_ovl: assert property (p_ovl) else $error("overload during push");
  property p_ign; lost_ev && !ms_tick |=> rin_acc == $past(rin_acc); endproperty
  a_ign: assert property (p_ign) else $error("pulse taken while disabled");
  property p_mul;
    take && p.mult && !p.dir && !ms_tick
      |=> rin_acc == $past(rin_acc) + signed'({11'h000, ctrl_reg.mult});
  endproperty
  a_mul: assert property (p_mul) else $error("multiply factor wrong");
  property p_tc; tc_reg <= spio_pkg::TC_MAX; endproperty
  a_tc: assert property (p_tc) else $error("time constant out of range");
  property p_start; prq_state == spio_pkg::PRQ_ARMED && rise.monitor_clock_input |=> o_prq_ready
    ##0 prq_state == spio_pkg::PRQ_SEND; endproperty
  a_start: assert property (p_start) else $error("request train not started");
  property p_end; prq_state == spio_pkg::PRQ_SEND && prq_left == 32'h0
    |=> !o_prq_ready; endproperty
  a_end: assert property (p_end) else $error("request ready stuck");
  property p_ser; rise.monitor_clock_input && !ctrl_reg.mon_pulse && bit_cnt == 6'h00
    |=> o_mon_data == $past(pos_sel[0]); endproperty
  a_ser: assert property (p_ser) else $error("serial first bit wrong");
  property p_wait; !o_waitrequest |=> o_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("waitrequest low twice");
  c_lost: cover property (lost_ev ##[1:50] rise.latch_clr);
  c_send: cover property (prq_state == spio_pkg::PRQ_SEND ##[1:1000] !o_prq_ready);
  c_frame: cover property (bit_cnt == spio_pkg::FRAME_LAST && rise.monitor_clock_input);
endmodule // spio_top
`default_nettype wire

// *** verification/spio_master.sv ***
// Purpose: Master controller model: step pulses and monitor clock.
// Assumes: Steps go out only while pulse ready is high, unless forced.
// Notes: Step period 12 cycles, monitor clock period 8 cycles (800 ns).
`timescale 1ns/1ns
`default_nettype none
module spio_master (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_ready,    // Pulse ready from the device.
  input  wire logic        i_force,    // Send steps even while not ready.
  input  wire logic        i_go_step,  // Starts a step burst.
  input  wire logic        i_go_mon,   // Starts a monitor clock burst.
  input  wire logic [7:0]  i_n,        // Burst length.
  input  wire logic        i_mon_data, // Serial data from the device.
  output logic             o_step,
  output logic             o_monitor_clock_input,
  output logic             o_busy,
  output logic [47:0]      o_frame     // Received bits, first one at bit 0.
);
  logic [7:0] st_left_reg; // Steps still to send.
  logic [3:0] st_ph_reg;   // Phase in the step period.
  logic [7:0] mc_left_reg; // Monitor clocks still to send.
  logic [2:0] mc_ph_reg;   // Phase in the monitor clock period.
  // Steps idle low while waiting for ready, then run 6 low and 6 high cycles.
  always_ff @(posedge i_clk) begin
    if (i_srst || i_go_step) begin
      st_left_reg <= i_srst ? 8'h00 : i_n;
      st_ph_reg   <= 4'h6;
    end else if (st_left_reg != 8'h00 && (i_ready || i_force)) begin
      st_ph_reg <= (st_ph_reg == 4'hB) ? 4'h0 : st_ph_reg + 4'h1;
      if (st_ph_reg == 4'h5) begin
        st_left_reg <= st_left_reg - 8'h01;
      end
    end
  end
  // The clock stands low outside bursts; a bit is taken just before the next rise.
  always_ff @(posedge i_clk) begin
    if (i_srst || i_go_mon) begin
      mc_left_reg <= i_srst ? 8'h00 : i_n;
      mc_ph_reg   <= 3'h0;
    end else if (mc_left_reg != 8'h00) begin
      mc_ph_reg <= mc_ph_reg + 3'h1;
      if (mc_ph_reg == 3'h7) begin
        mc_left_reg <= mc_left_reg - 8'h01;
        o_frame     <= {i_mon_data, o_frame[47:1]};
      end
    end
  end
  // Pins are decoded from registers, so they change just after an edge.
  assign o_step    = (st_left_reg != 8'h00) && (st_ph_reg < 4'h6);
  assign o_monitor_clock_input = (mc_left_reg != 8'h00) && (mc_ph_reg < 3'h4);
  assign o_busy    = (st_left_reg != 8'h00) || (mc_left_reg != 8'h00);
endmodule // spio_master
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: Self-checking bench of the pulse-input front end.
// Assumes: A 10 MHz clock and a millisecond tick shortened to 20 cycles.
// Notes: Register cases run from a table; the other cases are hand-written.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int PREP = 300; // Start-up preparation cycles.
  localparam int DEN  = 2 * spio_pkg::HZ_PER_UNIT * int'(spio_pkg::MAXF_MAX);
  localparam int GAP  = 2 * ((spio_pkg::CLK_HZ + DEN - 1) / DEN); // Fastest request period.
  typedef struct packed {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
  } spio_row_s; // A write, or a read with its expected value.
  localparam spio_row_s ROWS [15] = '{
    '{1'b0, spio_pkg::A_CTRL, spio_pkg::CTRL_RST},
    '{1'b0, spio_pkg::A_TCONST, 32'(spio_pkg::TC_RST)},
    '{1'b0, spio_pkg::A_MAXF, 32'(spio_pkg::MAXF_RST)},
    '{1'b1, spio_pkg::A_TCONST, 32'(spio_pkg::TC_MAX)},
    '{1'b1, spio_pkg::A_TCONST, 32'h000000C9},
    '{1'b0, spio_pkg::A_TCONST, 32'(spio_pkg::TC_MAX)},
    '{1'b1, spio_pkg::A_MAXF, 32'h00000000},
    '{1'b0, spio_pkg::A_MAXF, 32'(spio_pkg::MAXF_RST)},
    '{1'b1, spio_pkg::A_MAXF, 32'(spio_pkg::MAXF_MAX)},
    '{1'b1, spio_pkg::A_CTRL, 32'h00000A02},
    '{1'b1, spio_pkg::A_CTRL, 32'h00000A03},
    '{1'b1, spio_pkg::A_CTRL, 32'h00001F02},
    '{1'b0, spio_pkg::A_CTRL, 32'h00000A02},
    '{1'b0, 8'h20, 32'h00000000},
    '{1'b1, spio_pkg::A_TCONST, 32'h00000003}};
  logic        clk = 1'b0, srst = 1'b1, excited = 1'b0, stop = 1'b0, ovl = 1'b0;
  logic        dir = 1'b0, lclr = 1'b0, mult = 1'b0, dis = 1'b0, push = 1'b0;
  logic        rsel = 1'b0, read = 1'b0, write = 1'b0, frc = 1'b0, go_s = 1'b0;
  logic        go_m = 1'b0, prv = 1'b0;
  logic [7:0]  addr = 8'h00, alarm = 8'hA5, nb = 8'h00;
  logic [31:0] wdata = 32'h0, fb = 32'h0, q, rdata;
  logic [1:0]  qab;
  logic [47:0] frame;
  logic        step, mclk, busy, wreq, rdy, led, prdy, lost, alm, mdata, preq, pdir;
  logic        prq_rdy, pa, pb;
  int          n_fail = 0, n_tests = 0, k, cnt, gap, last;
  spio_top #(.MS_CYC_P(20), .PREP_CYC(PREP)) dut (
    .i_clk(clk), .i_srst(srst), .i_pins({rsel, push, dis, mult, lclr, mclk, dir, step}),
    .i_excited(excited), .i_stop(stop), .i_overload(ovl), .i_fb_pos(fb),
    .i_alarm_code(alarm), .i_address(addr), .i_read(read), .i_write(write),
    .i_writedata(wdata), .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(wreq),
    .o_ready(rdy), .o_ready_led(led), .o_pulse_ready(prdy), .o_lost_flag(lost),
    .o_overload_alarm(alm), .o_mon_data(mdata), .o_pulse_req(preq),
    .o_pulse_req_dir(pdir), .o_prq_ready(prq_rdy), .o_phase_a(pa), .o_phase_b(pb));
  spio_master master (.i_clk(clk), .i_srst(srst), .i_ready(prdy), .i_force(frc),
    .i_go_step(go_s), .i_go_mon(go_m), .i_n(nb), .i_mon_data(mdata), .o_step(step),
    .o_monitor_clock_input(mclk), .o_busy(busy), .o_frame(frame));
  // The clock toggles every half period of 50 ns.
  always #50 clk = ~clk;
  // Compares one value, counts it and reports a mismatch.
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (e !== g) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits a number of cycles.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bus transfer, held until waitrequest is sampled low; read data lands in q.
  // Only the watchdog ends a transfer that never completes.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Sends a step or monitor clock burst and waits until it is over.
  task automatic burst(input logic mon, input logic [7:0] n, input logic f);
    @(posedge clk);
    nb <= n;
    frc <= f;
    go_s <= ~mon;
    go_m <= mon;
    @(posedge clk);
    go_s <= 1'b0;
    go_m <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy !== 1'b0 && k < 3000);
    cyc(12);
    if (k >= 3000) n_fail++;
  endtask
  // Lets the filter settle, then reads and checks the command position.
  task automatic pos(input string nm, input logic [31:0] e);
    cyc(200);
    bus(1'b0, spio_pkg::A_CPOS, 32'h0);
    chk(nm, e, q);
  endtask
  // Marks the end of a test.
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Cuts a hang short well after the expected run length.
  initial begin
    cyc(30000);
    n_fail++;
    print_verdict();
  end
  // Main sequence: reset, register table, then the hand-written cases.
  initial begin
    cyc(8);
    chk("wait_in_reset", 1, wreq);
    srst <= 1'b0;
    cyc(PREP - 4);
    chk("ready_early", 2'b00, {rdy, led});
    cyc(8);
    chk("ready_led", 2'b11, {rdy, led});
    done("reset");
    foreach (ROWS[i]) begin
      bus(ROWS[i].wr, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].wr) chk("register", ROWS[i].d, q);
    end
    done("registers");
    chk("pulse_ready_off", 0, prdy);
    burst(1'b0, 8'h03, 1'b1);
    chk("lost_flag", 1, lost);
    bus(1'b0, spio_pkg::A_LOST, 32'h0);
    chk("lost_count", 3, q);
    lclr <= 1'b1;
    cyc(10);
    chk("lost_cleared", 0, lost);
    lclr <= 1'b0;
    excited <= 1'b1;
    cyc(3);
    chk("pulse_ready", 1, prdy);
    stop <= 1'b1;
    cyc(3);
    chk("pulse_ready_stop", 0, prdy);
    stop <= 1'b0;
    dis <= 1'b1;
    cyc(8);
    chk("pulse_ready_dis", 0, prdy);
    bus(1'b1, spio_pkg::A_CTRL, 32'h00010A02);
    dir <= 1'b1;
    burst(1'b0, 8'h02, 1'b1);
    bus(1'b0, spio_pkg::A_LOST, 32'h0);
    chk("lost_signed", 1, q);
    pos("cpos_disabled", 0);
    dis <= 1'b0;
    dir <= 1'b0;
    done("lost pulses");
    burst(1'b0, 8'h05, 1'b0);
    pos("cpos_fwd", 5);
    mult <= 1'b1;
    burst(1'b0, 8'h02, 1'b0);
    pos("cpos_mult", 25);
    mult <= 1'b0;
    dir <= 1'b1;
    burst(1'b0, 8'h01, 1'b0);
    pos("cpos_back", 24);
    dir <= 1'b0;
    bus(1'b1, spio_pkg::A_CTRL, 32'h00000A01);
    burst(1'b0, 8'h01, 1'b0);
    pos("cpos_lpf", 25);
    done("command position");
    ovl <= 1'b1;
    cyc(3);
    chk("overload", 1, alm);
    push <= 1'b1;
    cyc(8);
    chk("overload_push", 0, alm);
    ovl <= 1'b0;
    push <= 1'b0;
    fb <= 32'h00000123;
    cyc(400);
    qab = ~{pa, pb}; // Two quadrature steps on invert both phases.
    fb <= 32'h00000125;
    cyc(10);
    chk("quadrature", qab, {pa, pb});
    done("alarm and quadrature");
    bus(1'b1, spio_pkg::A_CTRL, 32'h00200A02);
    burst(1'b1, 8'd48, 1'b0);
    chk("serial", {fb[7:0] + fb[15:8] + fb[23:16] + fb[31:24] + alarm, alarm, fb}, frame);
    done("serial monitor");
    bus(1'b1, spio_pkg::A_CTRL, 32'h01000A02);
    rsel <= 1'b1;
    cyc(10);
    chk("prq_ready", 1, prq_rdy);
    nb <= 8'h01;
    go_m <= 1'b1;
    cyc(1);
    go_m <= 1'b0;
    k = 0;
    cnt = 0;
    gap = 1000;
    last = -1000;
    while (prq_rdy === 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
      if (preq === 1'b1 && prv === 1'b0) begin
        cnt++;
        gap = (k - last < gap) ? k - last : gap;
        last = k;
      end
      prv = preq;
    end
    chk("prq_count", 25, cnt);
    chk("prq_period", GAP, gap);
    chk("prq_end", 3'b000, {prq_rdy, preq, pdir});
    done("pulse request");
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
